// ### ctrf_pkg.sv
// Purpose: Shared constants for the cycle timer and upper request filter
// Assumes: 32-bit register words, byte offsets on the register port
// Notes: Timer fields are packed seconds | cycle index | in-cycle tick
package ctrf_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam int CTRF_ADDR_W = 12;
   localparam logic [11:0] CTRF_OFS_CYCLE_TIME = 12'h0f0;
   localparam logic [11:0] CTRF_OFS_ACCEPT_SET = 12'h100;
   localparam logic [11:0] CTRF_OFS_ACCEPT_CLR = 12'h104;

   // ------------------------------------------------------------
   // Cycle timer field layout
   // ------------------------------------------------------------
   localparam int CTRF_SEC_LSB = 25;
   localparam int CTRF_SEC_W = 7;
   localparam int CTRF_CNT_LSB = 12;
   localparam int CTRF_CNT_W = 13;
   localparam int CTRF_TICK_W = 12;
   localparam logic [6:0] CTRF_SEC_ONE = 7'h01;
   localparam logic [12:0] CTRF_CNT_LAST = 13'h1f3f;
   localparam logic [12:0] CTRF_CNT_ONE = 13'h0001;
   localparam logic [12:0] CTRF_CNT_ZERO = 13'h0000;
   localparam logic [11:0] CTRF_TICK_LAST = 12'hbff;
   localparam logic [11:0] CTRF_TICK_ONE = 12'h001;
   localparam logic [11:0] CTRF_TICK_ZERO = 12'h000;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] CTRF_TIMER_RST = 32'h0000_0000;
   localparam logic [31:0] CTRF_FILTER_RST = 32'h0000_0000;
   localparam logic [31:0] CTRF_RDATA_RST = 32'h0000_0000;

   // ------------------------------------------------------------
   // Filter layout and node identifiers
   // ------------------------------------------------------------
   localparam int CTRF_ALLBUS_BIT = 31;
   localparam int CTRF_BUS_LSB = 6;
   localparam int CTRF_BUS_W = 10;
   localparam int CTRF_NODE_W = 6;
   localparam logic [5:0] CTRF_NODE_BASE = 6'h20;
   localparam logic [5:0] CTRF_NODE_TOP = 6'h3e;
   localparam logic [5:0] CTRF_NODE_INVALID = 6'h3f;
   localparam logic [9:0] CTRF_BUS_LOCAL = 10'h3ff;

endpackage

// ### ctrf_tmr_if.sv
// Purpose: Carries control and value between register logic and timer
// Assumes: Single clock domain
// Notes: ctl side drives commands, tmr side drives the count value
`timescale 1ns/10ps
interface ctrf_tmr_if;
   logic ce;
   logic sw_wr;
   logic [31:0] sw_data;
   logic cs_load;
   logic [31:0] cs_data;
   logic run;
   logic tick;
   logic ext_zero;
   logic [31:0] value;

   modport ctl (
      output ce, sw_wr, sw_data, cs_load, cs_data, run, tick, ext_zero,
      input value
   );
   modport tmr (
      input ce, sw_wr, sw_data, cs_load, cs_data, run, tick, ext_zero,
      output value
   );
endinterface

// ### ctrf_cycle_timer.sv
// Purpose: Seconds / cycle index / in-cycle tick counter
// Assumes: tick is a one-cycle pulse at the 24.576 MHz rate
// Notes: Software write beats a cycle start load, which beats counting
`timescale 1ns/10ps
module ctrf_cycle_timer (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Timer control and value
   ctrf_tmr_if.tmr tif
);
   import ctrf_pkg::*;

   logic [31:0] value_r;
   logic [31:0] value_nxt;
   logic [CTRF_SEC_W-1:0] sec;
   logic [CTRF_CNT_W-1:0] cnt;
   logic [CTRF_TICK_W-1:0] tck;
   logic adv;

   assign tif.value = value_r;

   always_comb begin
      sec = value_r[CTRF_SEC_LSB +: CTRF_SEC_W];
      cnt = value_r[CTRF_CNT_LSB +: CTRF_CNT_W];
      tck = value_r[CTRF_TICK_W-1:0];
      adv = 1'b0;
      value_nxt = value_r;
      if (tif.sw_wr) begin
         value_nxt = tif.sw_data;
      end else if (tif.cs_load) begin
         value_nxt = tif.cs_data;
      end else if (tif.run) begin
         if (tif.ext_zero) begin
            tck = CTRF_TICK_ZERO;
            adv = 1'b1;
         end else if (tif.tick) begin
            if (tck == CTRF_TICK_LAST) begin
               tck = CTRF_TICK_ZERO;
               adv = 1'b1;
            end else begin
               tck = tck + CTRF_TICK_ONE;
            end
         end
         if (adv) begin
            if (cnt == CTRF_CNT_LAST) begin
               cnt = CTRF_CNT_ZERO;
               sec = sec + CTRF_SEC_ONE;
            end else begin
               cnt = cnt + CTRF_CNT_ONE;
            end
         end
         value_nxt = {sec, cnt, tck};
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         value_r <= CTRF_TIMER_RST;
      end else if (tif.ce) begin
         value_r <= value_nxt;
      end
   end

endmodule

// ### ctrf_top.sv
// Purpose: Cycle timer register and upper asynchronous request filter
// Assumes: Register port, packet and cycle start strobes on i_mclk
// Notes: Only the external cycle reference pin is synchronised
//
// Function
// - Seconds field advances on each cycle index wrap, modulo 128.
// - Cycle index advances on each tick wrap, modulo 8000.
// - In-cycle tick counts 24.576 MHz periods modulo 3072.
// - External 8 kHz reference forces the tick field to zero.
// - As cycle master, send current timer value in cycle start.
// - When not master, load timer from each received cycle start.
// - Free-running keeps the timer counting without cycle starts.
// - Timer is readable and writable, and keeps counting after writes.
// - Every packet for physical or request queue is filtered by source.
// - Clear bit for local source means no acknowledge and no enqueue.
// - Per-node bits apply only to sources on the local bus.
// - Remote-bus requests accepted only when bit 31 is set.
// - Filter is set at 100h, cleared at 104h, resets to zero.
// - Bit n, for n up to 30, enables local node n plus 32.
// - Own node number 63 blocks transmit contexts.
// - Own bus number classifies sources as local or remote.
`timescale 1ns/10ps
module ctrf_top (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   // Register port
   input wire logic [ctrf_pkg::CTRF_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Link configuration
   input wire logic i_cycle_master,
   input wire logic i_free_run,
   input wire logic i_ext_ref_en,
   input wire logic [ctrf_pkg::CTRF_BUS_W-1:0] i_local_bus_id,
   input wire logic [ctrf_pkg::CTRF_NODE_W-1:0] i_local_node_id,
   output logic o_tx_inhibit,
   // Cycle timing
   input wire logic i_cyc_tick,
   input wire logic i_ext_ref,
   // Cycle start transmit
   input wire logic i_cs_tx_req,
   output logic o_cs_tx_valid,
   output logic [31:0] o_cs_tx_data,
   // Cycle start receive
   input wire logic i_cs_rx_valid,
   input wire logic [31:0] i_cs_rx_data,
   // Receive packet filter
   input wire logic i_pkt_valid,
   input wire logic [15:0] i_pkt_src_id,
   output logic o_flt_valid,
   output logic o_flt_upper,
   output logic o_flt_accept
);
   import ctrf_pkg::*;

   // ------------------------------------------------------------
   // External reference synchroniser
   // ------------------------------------------------------------
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_s3_r;
   logic ext_edge;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else if (i_ce) begin
         ext_s1_r <= i_ext_ref;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   // Rising edge seen only past the second stage
   assign ext_edge = ext_s2_r & ~ext_s3_r;

   // ------------------------------------------------------------
   // Cycle timer
   // ------------------------------------------------------------
   ctrf_tmr_if tif ();

   logic wr_timer;

   assign wr_timer = i_wr && (i_addr == CTRF_OFS_CYCLE_TIME);
   assign tif.ce = i_ce;
   assign tif.sw_wr = wr_timer;
   assign tif.sw_data = i_wdata;
   assign tif.cs_load = i_cs_rx_valid && !i_cycle_master;
   assign tif.cs_data = i_cs_rx_data;
   assign tif.run = i_cycle_master || i_free_run;
   assign tif.tick = i_cyc_tick;
   assign tif.ext_zero = i_ext_ref_en && ext_edge;

   ctrf_cycle_timer u_timer (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .tif(tif)
   );

   // ------------------------------------------------------------
   // Request filter register and read port
   // ------------------------------------------------------------
   logic [31:0] flt_r;
   logic [31:0] flt_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   always_comb begin
      flt_nxt = flt_r;
      if (i_wr && (i_addr == CTRF_OFS_ACCEPT_SET)) begin
         flt_nxt = flt_r | i_wdata;
      end
      if (i_wr && (i_addr == CTRF_OFS_ACCEPT_CLR)) begin
         flt_nxt = flt_r & ~i_wdata;
      end
      rdata_nxt = CTRF_RDATA_RST;
      if (i_rd) begin
         unique case (i_addr)
            CTRF_OFS_CYCLE_TIME: begin
               rdata_nxt = tif.value;
            end
            CTRF_OFS_ACCEPT_SET, CTRF_OFS_ACCEPT_CLR: begin
               rdata_nxt = flt_r;
            end
            default: begin
               rdata_nxt = CTRF_RDATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flt_r <= CTRF_FILTER_RST;
         rdata_r <= CTRF_RDATA_RST;
      end else if (i_ce) begin
         flt_r <= flt_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;

   // ------------------------------------------------------------
   // Source filter decision
   // ------------------------------------------------------------
   logic [CTRF_BUS_W-1:0] src_bus;
   logic [CTRF_NODE_W-1:0] src_node;
   logic src_local;
   logic src_upper;
   logic flt_valid_r;
   logic flt_valid_nxt;
   logic flt_upper_r;
   logic flt_upper_nxt;
   logic flt_accept_r;
   logic flt_accept_nxt;

   always_comb begin
      src_bus = i_pkt_src_id[CTRF_BUS_LSB +: CTRF_BUS_W];
      src_node = i_pkt_src_id[CTRF_NODE_W-1:0];
      src_local = (src_bus == CTRF_BUS_LOCAL) || (src_bus == i_local_bus_id);
      src_upper = (src_node >= CTRF_NODE_BASE) && (src_node <= CTRF_NODE_TOP);
      flt_valid_nxt = i_pkt_valid;
      flt_upper_nxt = 1'b0;
      flt_accept_nxt = 1'b0;
      if (i_pkt_valid) begin
         if (src_local) begin
            flt_upper_nxt = src_upper;
            flt_accept_nxt = src_upper && flt_nxt[src_node[4:0]];
         end else begin
            flt_upper_nxt = 1'b1;
            flt_accept_nxt = flt_nxt[CTRF_ALLBUS_BIT];
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flt_valid_r <= 1'b0;
         flt_upper_r <= 1'b0;
         flt_accept_r <= 1'b0;
      end else if (i_ce) begin
         flt_valid_r <= flt_valid_nxt;
         flt_upper_r <= flt_upper_nxt;
         flt_accept_r <= flt_accept_nxt;
      end
   end

   assign o_flt_valid = flt_valid_r;
   assign o_flt_upper = flt_upper_r;
   assign o_flt_accept = flt_accept_r;

   // ------------------------------------------------------------
   // Cycle start transmit and node status
   // ------------------------------------------------------------
   logic cs_tx_valid_r;
   logic cs_tx_valid_nxt;
   logic [31:0] cs_tx_data_r;
   logic [31:0] cs_tx_data_nxt;
   logic tx_inhibit_r;
   logic tx_inhibit_nxt;

   always_comb begin
      cs_tx_valid_nxt = i_cs_tx_req && i_cycle_master;
      cs_tx_data_nxt = cs_tx_data_r;
      if (cs_tx_valid_nxt) begin
         cs_tx_data_nxt = tif.value;
      end
      tx_inhibit_nxt = (i_local_node_id == CTRF_NODE_INVALID);
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cs_tx_valid_r <= 1'b0;
         cs_tx_data_r <= CTRF_TIMER_RST;
         tx_inhibit_r <= 1'b0;
      end else if (i_ce) begin
         cs_tx_valid_r <= cs_tx_valid_nxt;
         cs_tx_data_r <= cs_tx_data_nxt;
         tx_inhibit_r <= tx_inhibit_nxt;
      end
   end

   assign o_cs_tx_valid = cs_tx_valid_r;
   assign o_cs_tx_data = cs_tx_data_r;
   assign o_tx_inhibit = tx_inhibit_r;

endmodule

// ### ctrf_phy_model.sv
// Purpose: Far-side model feeding ticks and received cycle starts
// Assumes: Commands from the bench arrive just after a rising edge
// Notes: Cycle start data is not held between frames
`timescale 1ns/10ps
module ctrf_phy_model (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset_n,
   // Bench commands
   input wire logic i_tick_en,
   input wire logic i_cs_go,
   input wire logic [31:0] i_cs_val,
   // Toward the block
   output logic o_cyc_tick,
   output logic o_cs_valid,
   output logic [31:0] o_cs_data
);
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_cyc_tick <= 1'b0;
         o_cs_valid <= 1'b0;
         o_cs_data <= 32'h0;
      end else begin
         o_cyc_tick <= i_tick_en;
         o_cs_valid <= i_cs_go;
         // Toggle when idle so stale data never looks valid
         o_cs_data <= i_cs_go ? i_cs_val : ~o_cs_data;
      end
   end
endmodule

// ### ctrf_top_monitor.sv
// Purpose: Port-level checks for the cycle timer and upper filter
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound into every instance of the top module
`timescale 1ns/10ps
module ctrf_top_monitor
   import ctrf_pkg::*;
(
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   // Register port
   input wire logic [CTRF_ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   // Link side
   input wire logic i_cycle_master,
   input wire logic i_ext_ref_en,
   input wire logic [CTRF_BUS_W-1:0] i_local_bus_id,
   input wire logic [CTRF_NODE_W-1:0] i_local_node_id,
   input wire logic o_tx_inhibit,
   input wire logic i_cyc_tick,
   input wire logic i_cs_tx_req,
   input wire logic o_cs_tx_valid,
   input wire logic i_cs_rx_valid,
   input wire logic [31:0] i_cs_rx_data,
   // Filter
   input wire logic i_pkt_valid,
   input wire logic [15:0] i_pkt_src_id,
   input wire logic o_flt_valid,
   input wire logic o_flt_upper,
   input wire logic o_flt_accept
);
   logic rmt;
   logic [5:0] nd;
   assign nd = i_pkt_src_id[5:0];
   assign rmt = i_pkt_src_id[15:6] != CTRF_BUS_LOCAL && i_pkt_src_id[15:6] != i_local_bus_id;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   a_flt_pulse: assert property (i_ce && i_pkt_valid |=> o_flt_valid)
      else $error("filter answer missing");
   a_flt_upper: assert property (i_ce && i_pkt_valid |=>
      o_flt_upper == $past(rmt || (nd >= CTRF_NODE_BASE && nd <= CTRF_NODE_TOP)))
      else $error("wrong half decided");
   a_acc_gated: assert property (o_flt_accept |-> o_flt_valid && o_flt_upper)
      else $error("accept without decision");
   a_rd_idle: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
      else $error("read data outside read slot");
   a_tx_echo: assert property (i_ce && i_cs_tx_req && i_cycle_master |=> o_cs_tx_valid)
      else $error("cycle start not answered");
   a_rx_load: assert property (i_ce && i_cs_rx_valid && !i_cycle_master && !i_wr
      ##1 i_ce && i_rd && i_addr == CTRF_OFS_CYCLE_TIME |=> o_rdata == $past(i_cs_rx_data, 2))
      else $error("timer not loaded from cycle start");
   a_wr_read: assert property (i_ce && i_wr && i_addr == CTRF_OFS_CYCLE_TIME
      ##1 i_ce && !i_cyc_tick && !i_cs_rx_valid && !i_wr && !i_ext_ref_en
      ##1 i_ce && i_rd && i_addr == CTRF_OFS_CYCLE_TIME |=> o_rdata == $past(i_wdata, 3))
      else $error("timer write not read back");
   a_tx_inhibit: assert property ($past(i_ce) |->
      o_tx_inhibit == ($past(i_local_node_id) == CTRF_NODE_INVALID))
      else $error("transmit inhibit wrong");

   c_accept: cover property (o_flt_accept);
   c_reject: cover property (o_flt_valid && o_flt_upper && !o_flt_accept);
   c_tx: cover property (o_cs_tx_valid);
endmodule
bind ctrf_top ctrf_top_monitor u_mon (.*);

// ### ctrf_top_test.sv
// Purpose: Self-checking bench for the timer and upper filter
// Assumes: Ticks and cycle starts come from the far-side model
// Notes: Timer wraps are reached by preloading near the boundary
`timescale 1ns/10ps
module ctrf_top_test;
   import ctrf_pkg::*;
   logic i_mclk, i_reset_n, i_ce, i_wr, i_rd, i_cycle_master, i_free_run, i_ext_ref_en;
   logic i_cyc_tick, i_ext_ref, i_cs_tx_req, i_cs_rx_valid, i_pkt_valid, tick_en, cs_go;
   logic o_tx_inhibit, o_cs_tx_valid, o_flt_valid, o_flt_upper, o_flt_accept;
   logic [CTRF_ADDR_W-1:0] i_addr;
   logic [31:0] i_wdata, o_rdata, o_cs_tx_data, i_cs_rx_data, cs_val;
   logic [9:0] i_local_bus_id;
   logic [5:0] i_local_node_id;
   logic [15:0] i_pkt_src_id;
   logic [31:0] st [3] = '{32'hfff3_fbfe, 32'h0bf3_f000, 32'h0001_0bff};
   logic [31:0] ex [3] = '{32'h0, 32'h0c00_0000, 32'h0001_1000};
   int nt [3] = '{2, 3072, 1};
   int fail_count = 0;
   int checked = 0;

   ctrf_top dut (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_cycle_master(i_cycle_master), .i_free_run(i_free_run), .i_ext_ref_en(i_ext_ref_en),
      .i_local_bus_id(i_local_bus_id), .i_local_node_id(i_local_node_id),
      .o_tx_inhibit(o_tx_inhibit), .i_cyc_tick(i_cyc_tick), .i_ext_ref(i_ext_ref),
      .i_cs_tx_req(i_cs_tx_req), .o_cs_tx_valid(o_cs_tx_valid), .o_cs_tx_data(o_cs_tx_data),
      .i_cs_rx_valid(i_cs_rx_valid), .i_cs_rx_data(i_cs_rx_data), .i_pkt_valid(i_pkt_valid),
      .i_pkt_src_id(i_pkt_src_id), .o_flt_valid(o_flt_valid), .o_flt_upper(o_flt_upper),
      .o_flt_accept(o_flt_accept));
   ctrf_phy_model u_phy (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_tick_en(tick_en),
      .i_cs_go(cs_go), .i_cs_val(cs_val), .o_cyc_tick(i_cyc_tick),
      .o_cs_valid(i_cs_rx_valid), .o_cs_data(i_cs_rx_data));

   initial begin
      i_mclk = 0;
      forever #2 i_mclk = ~i_mclk;
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr_reg(input logic [11:0] ad, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1;
      i_addr <= ad;
      i_wdata <= d;
      @(posedge i_mclk) i_wr <= 0;
   endtask
   task automatic rd_reg(input logic [11:0] ad, input logic [31:0] e);
      @(posedge i_mclk);
      i_rd <= 1;
      i_addr <= ad;
      @(posedge i_mclk) i_rd <= 0;
      #1 chk(o_rdata, e);
   endtask
   task automatic pkt(input logic [9:0] b, input logic [5:0] n, input logic [1:0] e);
      @(posedge i_mclk);
      i_pkt_valid <= 1;
      i_pkt_src_id <= {b, n};
      @(posedge i_mclk) i_pkt_valid <= 0;
      #1 chk({29'h0, o_flt_valid, o_flt_upper, o_flt_accept}, {29'h0, 1'b1, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk) tick_en <= 1;
      @(posedge i_mclk) tick_en <= 0;
      repeat (3) @(posedge i_mclk);
   endtask
   task automatic cs_rx(input logic [31:0] v);
      @(posedge i_mclk);
      cs_go <= 1;
      cs_val <= v;
      @(posedge i_mclk) cs_go <= 0;
   endtask
   task automatic cs_tx(input logic e);
      @(posedge i_mclk) i_cs_tx_req <= 1;
      @(posedge i_mclk) i_cs_tx_req <= 0;
      #1 chk({31'h0, o_cs_tx_valid}, {31'h0, e});
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {i_wr, i_rd, i_cycle_master, i_free_run, i_ext_ref_en, i_ext_ref} = '0;
      {i_cs_tx_req, i_pkt_valid, tick_en, cs_go} = '0;
      {i_addr, i_wdata, i_pkt_src_id, cs_val} = '0;
      i_ce = 1;
      i_reset_n = 0;
      i_local_bus_id = 10'h005;
      i_local_node_id = 6'h01;
      repeat (20) @(posedge i_mclk);
      i_reset_n <= 1;
      rd_reg(CTRF_OFS_ACCEPT_SET, 32'h0);
      rd_reg(12'h0f4, 32'h0);
      chk({31'h0, o_tx_inhibit}, 32'h0);
      wr_reg(CTRF_OFS_ACCEPT_SET, 32'h8000_0100);
      wr_reg(CTRF_OFS_ACCEPT_SET, 32'h4010_0000);
      wr_reg(CTRF_OFS_ACCEPT_CLR, 32'h0);
      rd_reg(CTRF_OFS_ACCEPT_CLR, 32'hc010_0100);
      pkt(10'h3ff, 6'h28, 2'b11);
      pkt(10'h005, 6'h3e, 2'b11);
      pkt(10'h3ff, 6'h34, 2'b11);
      pkt(10'h007, 6'h01, 2'b11);
      pkt(10'h3ff, 6'h29, 2'b10);
      pkt(10'h3ff, 6'h05, 2'b00);
      pkt(10'h3ff, 6'h3f, 2'b00);
      wr_reg(CTRF_OFS_ACCEPT_CLR, 32'h8000_0000);
      rd_reg(CTRF_OFS_ACCEPT_SET, 32'h4010_0100);
      pkt(10'h2a0, 6'h28, 2'b10);
      // Mid-run reset must empty the filter
      i_reset_n <= 0;
      repeat (2) @(posedge i_mclk);
      i_reset_n <= 1;
      rd_reg(CTRF_OFS_ACCEPT_CLR, 32'h0);
      pkt(10'h3ff, 6'h28, 2'b10);
      i_free_run <= 1;
      for (int i = 0; i < 3; i++) begin
         wr_reg(CTRF_OFS_CYCLE_TIME, st[i]);
         tick(nt[i]);
         rd_reg(CTRF_OFS_CYCLE_TIME, ex[i]);
      end
      i_free_run <= 0;
      wr_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_0123);
      rd_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_0123);
      tick(4);
      rd_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_0123);
      i_free_run <= 1;
      tick(4);
      i_ce <= 0;
      tick(4);
      i_ce <= 1;
      rd_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_0127);
      i_ext_ref_en <= 1;
      wr_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_0500);
      i_ext_ref <= 1;
      repeat (8) @(posedge i_mclk);
      i_ext_ref <= 0;
      i_ext_ref_en <= 0;
      rd_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_1000);
      // Reference edge ignored while not enabled
      wr_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_0500);
      i_ext_ref <= 1;
      repeat (8) @(posedge i_mclk);
      i_ext_ref <= 0;
      rd_reg(CTRF_OFS_CYCLE_TIME, 32'h0000_0500);
      cs_rx(32'h1357_9bdf);
      rd_reg(CTRF_OFS_CYCLE_TIME, 32'h1357_9bdf);
      cs_tx(1'b0);
      i_cycle_master <= 1;
      cs_rx(32'h0246_8ace);
      rd_reg(CTRF_OFS_CYCLE_TIME, 32'h1357_9bdf);
      cs_tx(1'b1);
      chk(o_cs_tx_data, 32'h1357_9bdf);
      i_local_node_id <= 6'h3f;
      repeat (3) @(posedge i_mclk);
      #1 chk({31'h0, o_tx_inhibit}, 32'h1);
      wrap_up;
   end

   initial begin
      repeat (20000) @(posedge i_mclk);
      fail_count++;
      wrap_up;
   end
endmodule
